// [tqs_pkg.sv]
// Package: register map, field layout, state codes and carriers for the transmit scan block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package tqs_pkg;
    // Register byte offsets
    localparam logic [7:0] TQS_OFS_SCAN_I0 = 8'h00;
    localparam logic [7:0] TQS_OFS_SCAN_I1 = 8'h04;
    localparam logic [7:0] TQS_OFS_SCAN_I2 = 8'h08;
    localparam logic [7:0] TQS_OFS_SCAN_I3 = 8'h0C;
    localparam logic [7:0] TQS_OFS_SCAN_U0 = 8'h10;
    localparam logic [7:0] TQS_OFS_SCAN_U1 = 8'h14;
    localparam logic [7:0] TQS_OFS_EVT_MASK = 8'h18;
    localparam logic [7:0] TQS_OFS_ERR_MASK = 8'h1C;
    localparam logic [7:0] TQS_OFS_CTRL = 8'h20;
    localparam logic [7:0] TQS_OFS_STATUS = 8'h24;
    // Field positions and reset values
    localparam int TQS_CTRL_POLL_BIT = 0;
    localparam int TQS_CTRL_IRQ_CLR_BIT = 1;
    localparam logic [15:0] TQS_SCAN_RST = 16'h0000;
    localparam logic [31:0] TQS_EVT_MASK_RST = 32'h0000_0000;
    localparam logic [3:0] TQS_ERR_MASK_RST = 4'h0;
    // Bits 31, 28 and 15 carry no event
    localparam logic [31:0] TQS_EVT_DEFINED = 32'h6FFF_7FFF;
    localparam logic [5:0] TQS_CODE_BUS_ERR = 6'h20;
    localparam logic [5:0] TQS_CODE_IQ_OVF = 6'h21;
    // Receive error bit positions
    localparam int TQS_ERR_LEN = 3;
    localparam int TQS_ERR_OVR = 2;
    localparam int TQS_ERR_ABT = 1;
    localparam int TQS_ERR_CRC = 0;
    // AXI responses
    localparam logic [1:0] TQS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TQS_RESP_SLVERR = 2'h2;
    // Scheduler states, one-hot; bit order is the service order
    typedef enum logic [5:0] {
        TQS_Q_I0 = 6'h01,
        TQS_Q_I1 = 6'h02,
        TQS_Q_I2 = 6'h04,
        TQS_Q_I3 = 6'h08,
        TQS_Q_U0 = 6'h10,
        TQS_Q_U1 = 6'h20
    } tqs_queue_t;
    typedef struct packed {
        logic valid;
        logic [5:0] code;
    } tqs_irq_entry_t;
    typedef struct packed {
        logic valid;
        logic keep;
        logic [3:0] err_code;
        logic [3:0] stat_dec;
        logic [2:0] cause;
    } tqs_rx_result_t;
endpackage

// [tqs_top.sv]
// Transmit queue scan, event mask and receive error keep logic with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module tqs_top import tqs_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write address and data
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // AXI4-Lite read
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [7:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // Transmit engine
    input wire logic [5:0] i_queue_ready,
    input wire logic i_frame_sent,
    output logic [5:0] o_tx_grant,
    // Event sources
    input wire logic [31:0] i_event,
    input wire logic i_bus_error,
    input wire logic i_irq_queue_overflow,
    output tqs_irq_entry_t o_irq_entry,
    output logic o_host_irq_pin,
    // Receive engine
    input wire logic i_rx_done,
    input wire logic [3:0] i_rx_err,
    input wire logic i_link_save_errors,
    input wire logic i_link_protocol_mode,
    output tqs_rx_result_t o_rx_result
);

//------------------------------------------------------------------------------
// Register bus
//------------------------------------------------------------------------------
logic [15:0] scan_r [6];
logic [31:0] evt_mask_r;
logic [3:0] err_mask_r;
logic poll_only_r;
logic awready_r, wready_r, aw_full_r, w_full_r, bvalid_r, arready_r, rvalid_r;
logic [7:0] awaddr_r;
logic [31:0] wdata_r, rdata_r;
logic [3:0] wstrb_r;
logic [1:0] bresp_r, rresp_r;
logic do_write;
logic irq_clr;
logic host_irq_r;
logic [33:0] pending_r;
logic [5:0] grant_r;
tqs_queue_t state_r;

function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                      input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
        if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
        end
    end
    return res;
endfunction

function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= TQS_OFS_STATUS);
endfunction

// Address and data are taken independently, in either order
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        awready_r <= 1'b0;
        aw_full_r <= 1'b0;
        awaddr_r <= 8'h00;
    end else begin
        awready_r <= i_s_axi_awvalid && !awready_r && !aw_full_r && !bvalid_r;
        if (i_s_axi_awvalid && awready_r) begin
            aw_full_r <= 1'b1;
            awaddr_r <= i_s_axi_awaddr;
        end else if (do_write) begin
            aw_full_r <= 1'b0;
        end
    end
end

always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        wready_r <= 1'b0;
        w_full_r <= 1'b0;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
    end else begin
        wready_r <= i_s_axi_wvalid && !wready_r && !w_full_r && !bvalid_r;
        if (i_s_axi_wvalid && wready_r) begin
            w_full_r <= 1'b1;
            wdata_r <= i_s_axi_wdata;
            wstrb_r <= i_s_axi_wstrb;
        end else if (do_write) begin
            w_full_r <= 1'b0;
        end
    end
end

assign do_write = aw_full_r && w_full_r && !bvalid_r;
assign irq_clr = do_write && (awaddr_r == TQS_OFS_CTRL) && wstrb_r[0]
                 && wdata_r[TQS_CTRL_IRQ_CLR_BIT];

// Write response; unmapped addresses answer SLVERR and store nothing
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        bvalid_r <= 1'b0;
        bresp_r <= TQS_RESP_OKAY;
    end else if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(awaddr_r) ? TQS_RESP_OKAY : TQS_RESP_SLVERR;
    end else if (i_s_axi_bready) begin
        bvalid_r <= 1'b0;
    end
end

// Configuration storage; scan lengths are full 16-bit counts
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        for (int q = 0; q < 6; q++) begin
            scan_r[q] <= TQS_SCAN_RST;
        end
        evt_mask_r <= TQS_EVT_MASK_RST;
        err_mask_r <= TQS_ERR_MASK_RST;
        poll_only_r <= 1'b0;
    end else if (do_write) begin
        if (awaddr_r <= TQS_OFS_SCAN_U1 && awaddr_r[1:0] == 2'h0) begin
            scan_r[awaddr_r[4:2]] <= {wstrb_r[1] ? wdata_r[15:8] : scan_r[awaddr_r[4:2]][15:8],
                                      wstrb_r[0] ? wdata_r[7:0] : scan_r[awaddr_r[4:2]][7:0]};
        end
        if (awaddr_r == TQS_OFS_EVT_MASK) begin
            evt_mask_r <= merge(evt_mask_r, wdata_r, wstrb_r);
        end
        // Only the low nibble is stored; upper bits read back as zero
        if (awaddr_r == TQS_OFS_ERR_MASK && wstrb_r[0]) begin
            err_mask_r <= wdata_r[3:0];
        end
        if (awaddr_r == TQS_OFS_CTRL && wstrb_r[0]) begin
            poll_only_r <= wdata_r[TQS_CTRL_POLL_BIT];
        end
    end
end

// Read channel: one cycle from address taken to data valid
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b0;
        rdata_r <= 32'h0000_0000;
        rresp_r <= TQS_RESP_OKAY;
    end else begin
        arready_r <= i_s_axi_arvalid && !arready_r && !rvalid_r;
        if (i_s_axi_arvalid && arready_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= addr_ok(i_s_axi_araddr) ? TQS_RESP_OKAY : TQS_RESP_SLVERR;
            rdata_r <= 32'h0000_0000;
            if (i_s_axi_araddr <= TQS_OFS_SCAN_U1 && i_s_axi_araddr[1:0] == 2'h0) begin
                rdata_r <= {16'h0000, scan_r[i_s_axi_araddr[4:2]]};
            end else if (i_s_axi_araddr == TQS_OFS_EVT_MASK) begin
                rdata_r <= evt_mask_r;
            end else if (i_s_axi_araddr == TQS_OFS_ERR_MASK) begin
                rdata_r <= {28'h0000000, err_mask_r};
            end else if (i_s_axi_araddr == TQS_OFS_CTRL) begin
                rdata_r <= {31'h00000000, poll_only_r};
            end else if (i_s_axi_araddr == TQS_OFS_STATUS) begin
                rdata_r <= {pending_r[33:32], 9'h000, host_irq_r, 2'h0, grant_r,
                            6'h00, state_r};
            end
        end else if (i_s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
end

//------------------------------------------------------------------------------
// Transmit queue scheduler
//------------------------------------------------------------------------------
logic [15:0] count_r;
logic [2:0] cur_idx;
logic [15:0] cur_len;
logic cur_ready, last_frame, advance;
tqs_queue_t state_nxt;

always_comb begin
    cur_idx = 3'h0;
    for (int q = 0; q < 6; q++) begin
        if (state_r[q]) begin
            cur_idx = 3'(q);
        end
    end
end

assign cur_len = scan_r[cur_idx];
assign cur_ready = i_queue_ready[cur_idx];
assign last_frame = i_frame_sent && (grant_r != 6'h00) && (count_r + 16'h0001 >= cur_len);
// Zero length or empty queue moves service on at once
assign advance = (cur_len == 16'h0000) || !cur_ready || last_frame;

// Fixed service order I0..I3, U0, U1, then back to I0
always_comb begin
    case (state_r)
        TQS_Q_I0: state_nxt = TQS_Q_I1;
        TQS_Q_I1: state_nxt = TQS_Q_I2;
        TQS_Q_I2: state_nxt = TQS_Q_I3;
        TQS_Q_I3: state_nxt = TQS_Q_U0;
        TQS_Q_U0: state_nxt = TQS_Q_U1;
        TQS_Q_U1: state_nxt = TQS_Q_I0;
        default: state_nxt = TQS_Q_I0;
    endcase
end

always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        state_r <= TQS_Q_I0;
        count_r <= 16'h0000;
    end else if (advance) begin
        state_r <= state_nxt;
        count_r <= 16'h0000;
    end else if (i_frame_sent && grant_r != 6'h00) begin
        count_r <= count_r + 16'h0001;
    end
end

// Grant only a queue with a nonzero length, frames waiting and turns left
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        grant_r <= 6'h00;
    end else begin
        grant_r <= advance ? 6'h00 : state_r;
    end
end

//------------------------------------------------------------------------------
// Event masking and interrupt queue entries
//------------------------------------------------------------------------------
logic [33:0] evt_new, evt_pick;
logic [5:0] pick_code;
tqs_irq_entry_t entry_r;

// Bus error and queue overflow bypass the mask
assign evt_new = {i_irq_queue_overflow, i_bus_error, i_event & evt_mask_r & TQS_EVT_DEFINED};

// Lowest pending bit is written first; one entry per cycle
always_comb begin
    evt_pick = 34'h0;
    pick_code = 6'h00;
    for (int b = 33; b >= 0; b--) begin
        if (pending_r[b]) begin
            evt_pick = 34'h1 << b;
            pick_code = 6'(b);
        end
    end
end

// New events set over the clearing of the one being written
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        pending_r <= 34'h0;
    end else begin
        pending_r <= (pending_r & ~evt_pick) | evt_new;
    end
end

always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        entry_r <= '0;
    end else begin
        entry_r.valid <= (pending_r != 34'h0);
        entry_r.code <= pick_code;
    end
end

// Pin rises on an entry unless polling only; a new entry beats a clear
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        host_irq_r <= 1'b0;
    end else if (entry_r.valid && !poll_only_r) begin
        host_irq_r <= 1'b1;
    end else if (irq_clr) begin
        host_irq_r <= 1'b0;
    end
end

//------------------------------------------------------------------------------
// Receive error keep decision
//------------------------------------------------------------------------------
logic mask_on;
logic [3:0] hit;
logic [2:0] cause;
tqs_rx_result_t rx_r;

assign mask_on = i_link_save_errors && i_link_protocol_mode;
assign hit = i_rx_err & err_mask_r & {4{mask_on}};

// First masked error in priority order names the cause
always_comb begin
    if (hit[TQS_ERR_OVR]) begin
        cause = 3'h1;
    end else if (hit[TQS_ERR_ABT]) begin
        cause = 3'h2;
    end else if (hit[TQS_ERR_CRC]) begin
        cause = 3'h3;
    end else if (hit[TQS_ERR_LEN]) begin
        cause = 3'h4;
    end else begin
        cause = 3'h0;
    end
end

// Discarded frames let the next frame overwrite the buffer
always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rx_r <= '0;
    end else begin
        rx_r.valid <= i_rx_done;
        rx_r.keep <= i_rx_done && ((i_rx_err == 4'h0) || (hit != 4'h0));
        rx_r.err_code <= i_rx_done ? i_rx_err : 4'h0;
        rx_r.stat_dec <= (i_rx_done && hit == 4'h0) ? i_rx_err : 4'h0;
        rx_r.cause <= i_rx_done ? cause : 3'h0;
    end
end

assign o_s_axi_awready = awready_r;
assign o_s_axi_wready = wready_r;
assign o_s_axi_bvalid = bvalid_r;
assign o_s_axi_bresp = bresp_r;
assign o_s_axi_arready = arready_r;
assign o_s_axi_rvalid = rvalid_r;
assign o_s_axi_rdata = rdata_r;
assign o_s_axi_rresp = rresp_r;
assign o_tx_grant = grant_r;
assign o_irq_entry = entry_r;
assign o_host_irq_pin = host_irq_r;
assign o_rx_result = rx_r;

//------------------------------------------------------------------------------
// Assertions
//------------------------------------------------------------------------------
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);

sequence s_last_sent;
    last_frame && !(cur_len == 16'h0000) && cur_ready;
endsequence

a_order_i3_u0: assert property ((state_r == TQS_Q_I3 && advance) |=> state_r == TQS_Q_U0)
    else $error("queue after I3 is not U0");
a_order_u1_i0: assert property ((state_r == TQS_Q_U1 && advance) |=> state_r == TQS_Q_I0)
    else $error("queue after U1 is not I0");
a_zero_no_grant: assert property ((cur_len == 16'h0000) |=> grant_r == 6'h00)
    else $error("zero scan length queue granted");
a_turn_ends: assert property (s_last_sent |=> grant_r == 6'h00 && count_r == 16'h0000)
    else $error("turn did not end at scan length");
a_count_bound: assert property ((grant_r != 6'h00) |-> count_r < cur_len)
    else $error("frames in turn exceed scan length");
a_masked_silent: assert property ((pending_r == 34'h0 && evt_new == 34'h0) |=> !entry_r.valid)
    else $error("entry without enabled event");
a_unmask_err: assert property (i_bus_error |->
    ##[1:34] (entry_r.valid && entry_r.code == TQS_CODE_BUS_ERR))
    else $error("bus error not reported");
a_irq_raise: assert property ((entry_r.valid && !poll_only_r) |=> host_irq_r)
    else $error("host interrupt not raised");
a_irq_poll: assert property ((!host_irq_r && poll_only_r && !entry_r.valid) |=> !host_irq_r)
    else $error("interrupt raised while polling only");
a_rx_keep: assert property ((i_rx_done && |hit) |=> (rx_r.keep && rx_r.stat_dec == 4'h0))
    else $error("masked error frame not kept");
a_rx_drop: assert property ((i_rx_done && |i_rx_err && !mask_on) |=> !rx_r.keep)
    else $error("errored frame kept without mask");
a_rx_code: assert property (i_rx_done |=> rx_r.err_code == $past(i_rx_err))
    else $error("error code not recorded");

endmodule

// [tqs_tx_model.sv]
// Transmit engine model: sends frames while granted, promptly or slowly
`timescale 1ns/100ps
module tqs_tx_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Grant from the scheduler and pacing select
    input wire logic [5:0] i_grant,
    input wire logic i_slow,
    // One pulse per finished frame
    output logic o_frame_sent
);
    int gap;
    // A gap of two or more cycles after each frame, so a grant that is
    // about to move never receives a spare frame
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap <= 0;
            o_frame_sent <= 1'b0;
        end else if (gap > 0) begin
            gap <= gap - 1;
            o_frame_sent <= 1'b0;
        end else if (i_grant != 6'h00) begin
            o_frame_sent <= 1'b1;
            gap <= 2 + (i_slow ? int'($urandom_range(3)) : 0);
        end else begin
            o_frame_sent <= 1'b0;
        end
    end
endmodule

// [tx_queue_scan_and_event_masking_tb.sv]
// Testbench: registers, queue scan order, event reporting, receive keep
`timescale 1ns/100ps
module tx_queue_scan_and_event_masking_tb import tqs_pkg::*;;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sent, slow, bus_err, iq_ovf;
    logic host_irq, rx_done, save_err, proto;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, event_in;
    logic [3:0] wstrb, rx_err;
    logic [1:0] bresp, rresp;
    logic [5:0] qready, grant;
    logic [5:0] prev_grant = 6'h00;
    tqs_irq_entry_t entry;
    tqs_rx_result_t rx_res;
    int miscompares, checks, turn_cnt;
    int obs_q[$], obs_n[$], codes[$], exp_codes[$];
    int len[6] = '{2, 0, 1, 3, 0, 1};

    tqs_top dut_u (.i_clk(clk), .i_rst_n(rst_n),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_queue_ready(qready),
        .i_frame_sent(sent), .o_tx_grant(grant), .i_event(event_in),
        .i_bus_error(bus_err), .i_irq_queue_overflow(iq_ovf), .o_irq_entry(entry),
        .o_host_irq_pin(host_irq), .i_rx_done(rx_done), .i_rx_err(rx_err),
        .i_link_save_errors(save_err), .i_link_protocol_mode(proto),
        .o_rx_result(rx_res));
    tqs_tx_model tx_u (.i_clk(clk), .i_rst_n(rst_n), .i_grant(grant), .i_slow(slow),
        .o_frame_sent(sent));

    //--------------------------------------------------------------------------
    // Checking and bus tasks
    //--------------------------------------------------------------------------
    task automatic end_of_test();
        $display("Counts: checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timed_out(input string what);
        miscompares++;
        $display("MISMATCH %s expected completion seen timeout", what);
        end_of_test();
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 60) timed_out("write");
        chk("bresp", er, bresp);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                      input logic [31:0] msk = 32'hFFFF_FFFF);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 60) timed_out("read");
        chk("rdata", ed & msk, rdata & msk);
        chk("rresp", er, rresp);
        rready <= 1'b0;
    endtask

    //--------------------------------------------------------------------------
    // Scheduler model: turns recorded at the ports against the service order
    //--------------------------------------------------------------------------
    function automatic int idx(input logic [5:0] g);
        for (int i = 0; i < 6; i++) if (g[i]) return i;
        return -1;
    endfunction
    // One record per finished turn; also collects event entries
    always @(posedge clk) begin
        if (grant != prev_grant && prev_grant != 6'h00) begin
            obs_q.push_back(idx(prev_grant));
            obs_n.push_back(turn_cnt);
            turn_cnt = 0;
        end
        if (sent && grant != 6'h00) turn_cnt++;
        prev_grant = grant;
        if (entry.valid === 1'b1) codes.push_back(int'(entry.code));
    end
    // First record may be a partial turn, so comparison starts at the second
    task automatic sched_run(input logic [5:0] rdy);
        int q, k;
        qready <= rdy;
        repeat (60) @(posedge clk);
        obs_q.delete();
        obs_n.delete();
        repeat (500) @(posedge clk);
        if (obs_q.size() < 6) timed_out("turns");
        q = obs_q[1];
        chk("first turn eligible", 1, len[q] != 0 && rdy[q]);
        for (k = 1; k < obs_q.size(); k++) begin
            chk("turn queue", q, obs_q[k]);
            chk("turn frames", len[q], obs_n[k]);
            do q = (q + 1) % 6; while (len[q] == 0 || !rdy[q]);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #800000;
        timed_out("run");
    end

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        int i, k;
        logic [31:0] m, v;
        logic [3:0] e, em, hit;
        logic sv, pr, kp;
        {awvalid, wvalid, bready, arvalid, rready, slow, bus_err, iq_ovf} = '0;
        {rx_done, save_err, proto} = '0;
        {awaddr, araddr, wdata, wstrb, event_in, rx_err} = '0;
        qready = 6'h00;
        rst_n = 1'b0;
        void'($urandom(28));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then the unmapped place
        for (i = 0; i < 9; i++) rd(8'(i * 4), 32'h0, TQS_RESP_OKAY);
        // State walks past zero-length queues every cycle, so only its shape is fixed
        rd(TQS_OFS_STATUS, 32'h0, TQS_RESP_OKAY, 32'hFFFF_FFC0);
        chk("status state one-hot", 1, $onehot(rdata[5:0]));
        rd(8'h28, 32'h0, TQS_RESP_SLVERR);
        wr(8'h28, 32'hFFFF_FFFF, 4'hF, TQS_RESP_SLVERR);
        // Scan lengths hold 16 bits each; no queue is ready yet
        for (i = 0; i < 6; i++) begin
            v = (i == 5) ? 32'hFFFF_FFFF : $urandom;
            wr(8'(i * 4), v, 4'hF, TQS_RESP_OKAY);
            rd(8'(i * 4), {16'h0000, v[15:0]}, TQS_RESP_OKAY);
        end
        wr(TQS_OFS_ERR_MASK, 32'h0000_000F, 4'hF, TQS_RESP_OKAY);
        rd(TQS_OFS_ERR_MASK, 32'h0000_000F, TQS_RESP_OKAY);
        wr(TQS_OFS_EVT_MASK, 32'hFFFF_FFFF, 4'h1, TQS_RESP_OKAY);
        rd(TQS_OFS_EVT_MASK, 32'h0000_00FF, TQS_RESP_OKAY);
        for (i = 0; i < 6; i++) wr(8'(i * 4), len[i], 4'hF, TQS_RESP_OKAY);
        sched_run(6'h3F);
        slow <= 1'b1;
        len[4] = 2;
        wr(TQS_OFS_SCAN_U0, 32'h2, 4'hF, TQS_RESP_OKAY);
        sched_run(6'h3B);
        qready <= 6'h00;
        // Each event bit once under a random mask
        m = $urandom | 32'h9001_0000;
        wr(TQS_OFS_EVT_MASK, m, 4'hF, TQS_RESP_OKAY);
        codes.delete();
        for (i = 0; i < 32; i++) begin
            @(posedge clk);
            event_in <= 32'h1 << i;
            @(posedge clk);
            event_in <= 32'h0;
            repeat (4) @(posedge clk);
            if (m[i] && TQS_EVT_DEFINED[i]) exp_codes.push_back(i);
        end
        chk("entry count", exp_codes.size(), codes.size());
        foreach (exp_codes[k]) chk("entry code", exp_codes[k], codes[k]);
        chk("host irq", 1, host_irq);
        wr(TQS_OFS_CTRL, 32'h2, 4'h1, TQS_RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("host irq cleared", 0, host_irq);
        // Polling only, all masked: only the two unmaskable reports appear
        wr(TQS_OFS_EVT_MASK, 32'h0, 4'hF, TQS_RESP_OKAY);
        wr(TQS_OFS_CTRL, 32'h1, 4'h1, TQS_RESP_OKAY);
        codes.delete();
        @(posedge clk);
        event_in <= 32'hFFFF_FFFF;
        bus_err <= 1'b1;
        iq_ovf <= 1'b1;
        @(posedge clk);
        {bus_err, iq_ovf} <= 2'b00;
        event_in <= 32'h0;
        repeat (8) @(posedge clk);
        chk("entries", 2, codes.size());
        chk("bus error code", TQS_CODE_BUS_ERR, codes[0]);
        chk("overflow code", TQS_CODE_IQ_OVF, codes[1]);
        chk("host irq polling", 0, host_irq);
        // Receive keep decisions under random errors, masks and link settings
        for (i = 0; i < 40; i++) begin
            em = 4'($urandom);
            e = 4'($urandom);
            sv = 1'($urandom);
            pr = 1'($urandom);
            wr(TQS_OFS_ERR_MASK, {28'h0, em}, 4'h1, TQS_RESP_OKAY);
            @(posedge clk);
            rx_done <= 1'b1;
            rx_err <= e;
            save_err <= sv;
            proto <= pr;
            @(posedge clk);
            rx_done <= 1'b0;
            @(posedge clk);
            hit = (sv && pr) ? (e & em) : 4'h0;
            kp = (e == 4'h0) || (hit != 4'h0);
            chk("rx valid", 1, rx_res.valid);
            chk("rx keep", kp, rx_res.keep);
            chk("rx error code", e, rx_res.err_code);
            chk("rx counter dec", kp ? 4'h0 : e, rx_res.stat_dec);
            chk("rx cause", (hit == 4'h0) ? 0 : hit[2] ? 1 : hit[1] ? 2 : hit[0] ? 3 : 4,
                                 rx_res.cause);
        end
        end_of_test();
    end
endmodule
